//--- bpp_params.svh
// Register map, field positions and reset values of the printer port block
`ifndef BPP_PARAMS_SVH
`define BPP_PARAMS_SVH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define BPP_ADR_DATA 2'h0
`define BPP_ADR_STATUS 2'h1
`define BPP_ADR_CONTROL 2'h2
`define BPP_ADR_INDIRECT 2'h3
`define BPP_ADR_HI_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPP_DATA_RST 8'h00
`define BPP_CTRL_RST 6'h00
`define BPP_INDEX_RST 8'h00
`define BPP_WDATA_RST 8'h00
`define BPP_RDATA_RST 8'h00

// ----------------------------------------
// Control fields
// ----------------------------------------
`define BPP_CTRL_STB 0
`define BPP_CTRL_AFD 1
`define BPP_CTRL_INIT 2
`define BPP_CTRL_SLIN 3
`define BPP_CTRL_IRQEN 4
`define BPP_CTRL_DIR 5
`define BPP_CTRL_RD_ONES 3'h7

// ----------------------------------------
// Status fields
// ----------------------------------------
`define BPP_STAT_LOW_ONES 2'h3

// ----------------------------------------
// Index register fields
// ----------------------------------------
`define BPP_IDX_TEST 7
`define BPP_IDX_SP0_HI 4
`define BPP_IDX_SP0_LO 3
`define BPP_IDX_SEL_HI 2
`define BPP_IDX_SEL_LO 0
`define BPP_IDX_CLKSEL 3'h0
`define BPP_IDX_CLKDIS 3'h1
`define BPP_IDX_LAST 3'h5
`define BPP_IDX_PARK 3'h7
`define BPP_NO_REG_DATA 8'hFF

`endif

//--- bpp_pkg.sv
// Types shared by the printer port register block
package bpp_pkg;

   // Register reached by one host cycle
   typedef enum logic [2:0] {
      BPP_REG_DATA,
      BPP_REG_STATUS,
      BPP_REG_CONTROL,
      BPP_REG_INDEX,
      BPP_REG_ACCESS
   } bpp_reg_t;

   // Serial port 0 clock source code
   typedef enum logic [1:0] {
      BPP_SP0_1M8432 = 2'h0,
      BPP_SP0_3M072 = 2'h1,
      BPP_SP0_EXT_MASTER = 2'h2,
      BPP_SP0_8M0 = 2'h3
   } bpp_sp0_clk_t;

endpackage

//--- bpp_dir_ctrl.sv
// Direction decision for the printer port data bus
`timescale 1ns/10ps

module bpp_dir_ctrl
   import bpp_pkg::*;
(
   input wire logic extended_bus_mode_in, // Extended bus mode selected
   input wire logic direction_pin_in, // External direction pin
   input wire logic direction_bit_in, // Stored control direction bit
   output logic drive_bus_out // High while the port drives the bus
);

   // ----------------------------------------
   // Direction table
   // ----------------------------------------
   logic read_ext;
   logic read_compat;

   // Extended reads only on pin and bit
   assign read_ext = direction_pin_in & direction_bit_in;
   assign read_compat = direction_pin_in;

   assign drive_bus_out = extended_bus_mode_in ? ~read_ext : ~read_compat;

endmodule

//--- bpp_port_regs.sv
// Host register logic of a bidirectional printer port
`timescale 1ns/10ps
`include "bpp_params.svh"

// Operation
// - Address 0 writes and reads port data bus
// - Address 1 returns live printer line status
// - Status bit 2 is interrupt only extended
// - Status bits 1 and 0 read one
// - Control write drives four printer output lines
// - Control bit 4 enables port interrupt
// - Control bits 7 and 6 ignored
// - Direction bit counts only in extended mode
// - Extended mode reads only pin and bit
// - Compatible mode direction follows pin alone
// - Control read returns stored bits 4-0
// - Control read bits 7-5 always one
// - Index bits 4-3 pick serial0 clock
// - Index bits 2-0 pick indirect register
// - Index 0 clock select, 1 clock disable
// - Index at 3, indirect data at 7
// - Test bit swaps mux interrupt sources
// - Mode bit picks interrupt style
module bpp_port_regs
   import bpp_pkg::*;
(
   input wire logic sys_clk_in, // 100 MHz system clock
   input wire logic rst_in, // Master reset, active high
   input wire logic port_chip_select_n_in, // Port chip select, active low
   input wire logic io_read_strobe_n_in, // Host read strobe, active low
   input wire logic io_write_strobe_n_in, // Host write strobe, active low
   input wire logic [2:0] addr_in, // Host address bits 2-0
   input wire logic [7:0] host_data_in, // Host write data
   output logic [7:0] host_data_out, // Host read data, registered
   output logic host_data_oe_out, // High while the block drives host data
   input wire logic [7:0] port_bus_in, // Printer data bus, pin level
   output logic [7:0] port_bus_out, // Printer data bus, driven value
   output logic port_bus_oe_out, // High while the block drives the bus
   input wire logic direction_pin_in, // External direction pin
   input wire logic busy_in, // Printer busy line
   input wire logic ack_in, // Printer acknowledge line
   input wire logic paper_end_in, // Printer paper end line
   input wire logic selected_in, // Printer select line
   input wire logic error_in, // Printer error line
   output logic strobe_out, // Printer strobe line
   output logic autofeed_out, // Printer autofeed line
   output logic init_out, // Printer initialize line
   output logic select_printer_out, // Printer select request line
   input wire logic extended_bus_mode_in, // Extended bus mode selection
   input wire logic extended_interrupt_mode_in, // Extended interrupt mode selection
   input wire logic port_irq_src_in, // Raw port interrupt event
   input wire logic serial0_irq_in, // Serial port 0 interrupt
   input wire logic serial1_irq_in, // Serial port 1 interrupt
   output logic port_irq_out, // Gated port interrupt
   output logic mux_serial0_irq_out, // Serial 0 input to interrupt mux
   output logic mux_serial1_irq_out, // Serial 1 input to interrupt mux
   output logic mux_port_irq_out, // Port input to interrupt mux
   output logic [1:0] serial0_clock_source_out, // Serial port 0 clock code
   output logic [2:0] indirect_index_field_out, // Selected indirect register
   output logic [7:0] indirect_wdata_out, // Indirect write data
   output logic indirect_wr_out, // Indirect write pulse, one cycle
   output logic indirect_rd_out, // Indirect read pulse, one cycle
   input wire logic [7:0] indirect_rdata_in, // Indirect read data
   output logic clock_select_wr_out, // Write pulse to clock select register
   output logic clock_disable_wr_out // Write pulse to clock disable register
);

   // ----------------------------------------
   // Host cycle detection
   // ----------------------------------------
   // Strobes are levels; one action per strobe
   // assertion avoids repeated side effects.
   logic wr_n_prev_q;
   logic rd_n_prev_q;
   logic selected;
   logic wr_start;
   logic rd_start;
   logic rd_active;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_n_prev_q <= 1'b1;
         rd_n_prev_q <= 1'b1;
      end else begin
         wr_n_prev_q <= io_write_strobe_n_in;
         rd_n_prev_q <= io_read_strobe_n_in;
      end
   end

   assign selected = ~port_chip_select_n_in;
   assign wr_start = selected & ~io_write_strobe_n_in & wr_n_prev_q
      & io_read_strobe_n_in;
   assign rd_start = selected & ~io_read_strobe_n_in & rd_n_prev_q
      & io_write_strobe_n_in;
   assign rd_active = selected & ~io_read_strobe_n_in
      & io_write_strobe_n_in;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   bpp_reg_t reg_sel;
   logic [1:0] adr_lo;
   logic adr_hi;

   assign adr_lo = addr_in[1:0];
   assign adr_hi = addr_in[`BPP_ADR_HI_BIT];

   // Index at 3, indirect data at 7
   always_comb begin
      reg_sel = BPP_REG_DATA;
      unique case (adr_lo)
         `BPP_ADR_DATA: reg_sel = BPP_REG_DATA;
         `BPP_ADR_STATUS: reg_sel = BPP_REG_STATUS;
         `BPP_ADR_CONTROL: reg_sel = BPP_REG_CONTROL;
         `BPP_ADR_INDIRECT: begin
            reg_sel = adr_hi ? BPP_REG_ACCESS : BPP_REG_INDEX;
         end
      endcase
   end

   logic wr_data;
   logic wr_ctrl;
   logic wr_index;
   logic wr_access;
   logic rd_status;
   logic rd_access;

   assign wr_data = wr_start & (reg_sel == BPP_REG_DATA);
   assign wr_ctrl = wr_start & (reg_sel == BPP_REG_CONTROL);
   assign wr_index = wr_start & (reg_sel == BPP_REG_INDEX);
   assign wr_access = wr_start & (reg_sel == BPP_REG_ACCESS);
   assign rd_status = rd_start & (reg_sel == BPP_REG_STATUS);
   assign rd_access = rd_start & (reg_sel == BPP_REG_ACCESS);

   // ----------------------------------------
   // Data and control registers
   // ----------------------------------------
   logic [7:0] data_q;
   logic [5:0] ctrl_q;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_q <= `BPP_DATA_RST;
      end else if (wr_data) begin
         data_q <= host_data_in;
      end
   end

   // Bits 7 and 6 not stored
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= `BPP_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= host_data_in[5:0];
      end
   end

   assign strobe_out = ctrl_q[`BPP_CTRL_STB];
   assign autofeed_out = ctrl_q[`BPP_CTRL_AFD];
   assign init_out = ctrl_q[`BPP_CTRL_INIT];
   assign select_printer_out = ctrl_q[`BPP_CTRL_SLIN];

   // ----------------------------------------
   // Data bus direction
   // ----------------------------------------
   logic drive_bus;

   bpp_dir_ctrl u_dir (
      .extended_bus_mode_in(extended_bus_mode_in),
      .direction_pin_in(direction_pin_in),
      .direction_bit_in(ctrl_q[`BPP_CTRL_DIR]),
      .drive_bus_out(drive_bus)
   );

   // Write data lands on the bus
   assign port_bus_out = data_q;
   assign port_bus_oe_out = drive_bus;

   // ----------------------------------------
   // Port interrupt
   // ----------------------------------------
   // Extended style holds the event until the
   // status is read; set wins over that clear.
   logic irq_latch_q;
   logic irq_ext;
   logic irq_raw;
   logic irq_gated;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_latch_q <= 1'b0;
      end else if (port_irq_src_in) begin
         irq_latch_q <= 1'b1;
      end else if (rd_status) begin
         irq_latch_q <= 1'b0;
      end
   end

   assign irq_ext = irq_latch_q | port_irq_src_in;
   assign irq_raw = extended_interrupt_mode_in ? irq_ext : port_irq_src_in;
   assign irq_gated = irq_raw & ctrl_q[`BPP_CTRL_IRQEN];
   assign port_irq_out = irq_gated;

   // ----------------------------------------
   // Index register
   // ----------------------------------------
   logic [7:0] index_q;
   logic [2:0] idx_sel;
   logic test_mode;
   logic idx_parked;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         index_q <= `BPP_INDEX_RST;
      end else if (wr_index) begin
         index_q <= host_data_in;
      end
   end

   assign idx_sel = index_q[`BPP_IDX_SEL_HI:`BPP_IDX_SEL_LO];
   assign test_mode = index_q[`BPP_IDX_TEST];
   assign idx_parked = (idx_sel > `BPP_IDX_LAST);

   assign serial0_clock_source_out = index_q[`BPP_IDX_SP0_HI:`BPP_IDX_SP0_LO];
   assign indirect_index_field_out = idx_sel;

   // ----------------------------------------
   // Indirect access
   // ----------------------------------------
   logic acc_wr;
   logic acc_rd;
   logic [7:0] wdata_q;
   logic acc_wr_q;
   logic acc_rd_q;
   logic clksel_wr_q;
   logic clkdis_wr_q;

   assign acc_wr = wr_access & ~idx_parked;
   assign acc_rd = rd_access & ~idx_parked;

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wdata_q <= `BPP_WDATA_RST;
         acc_wr_q <= 1'b0;
         acc_rd_q <= 1'b0;
      end else begin
         if (acc_wr) begin
            wdata_q <= host_data_in;
         end
         acc_wr_q <= acc_wr;
         acc_rd_q <= acc_rd;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clksel_wr_q <= 1'b0;
         clkdis_wr_q <= 1'b0;
      end else begin
         clksel_wr_q <= acc_wr & (idx_sel == `BPP_IDX_CLKSEL);
         clkdis_wr_q <= acc_wr & (idx_sel == `BPP_IDX_CLKDIS);
      end
   end

   assign indirect_wdata_out = wdata_q;
   assign indirect_wr_out = acc_wr_q;
   assign indirect_rd_out = acc_rd_q;
   assign clock_select_wr_out = clksel_wr_q;
   assign clock_disable_wr_out = clkdis_wr_q;

   // ----------------------------------------
   // Interrupt mux source swap
   // ----------------------------------------
   // Test bit swaps mux inputs
   assign mux_serial1_irq_out = test_mode ? selected_in : serial1_irq_in;
   assign mux_serial0_irq_out = test_mode ? busy_in : serial0_irq_in;
   assign mux_port_irq_out = test_mode ? paper_end_in : irq_gated;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [7:0] status_rd;
   logic [7:0] ctrl_rd;
   logic [7:0] access_rd;
   logic [7:0] rd_mux;
   logic int_bit;
   logic [7:0] rdata_q;

   // Interrupt bit only in extended mode
   assign int_bit = extended_interrupt_mode_in ? ~irq_raw : 1'b1;

   assign status_rd = {busy_in, ack_in, paper_end_in, selected_in,
      error_in, int_bit, `BPP_STAT_LOW_ONES};

   assign ctrl_rd = {`BPP_CTRL_RD_ONES, ctrl_q[4:0]};

   assign access_rd = idx_parked ? `BPP_NO_REG_DATA : indirect_rdata_in;

   always_comb begin
      rd_mux = port_bus_in;
      unique case (reg_sel)
         BPP_REG_DATA: rd_mux = port_bus_in;
         BPP_REG_STATUS: rd_mux = status_rd;
         BPP_REG_CONTROL: rd_mux = ctrl_rd;
         BPP_REG_INDEX: rd_mux = index_q;
         BPP_REG_ACCESS: rd_mux = access_rd;
         default: rd_mux = port_bus_in;
      endcase
   end

   // Sampled every cycle so the host sees live
   // status for as long as the strobe stands.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= `BPP_RDATA_RST;
      end else if (rd_active) begin
         rdata_q <= rd_mux;
      end
   end

   assign host_data_out = rdata_q;
   assign host_data_oe_out = rd_active;

endmodule

//--- bpp_printer_model.sv
// Printer side model: status lines and data bus pin level
`timescale 1ns/10ps
module bpp_printer_model (
   input wire logic [7:0] blk_bus_in, // Block drive value
   input wire logic blk_oe_in, // Block drives bus
   input wire logic [7:0] data_in, // Printer byte
   input wire logic [4:0] lines_in, // Busy ack pe slct err
   output logic [7:0] pin_out, // Bus pin level
   output logic [4:0] lines_out // Status pins
);
   // Printer drives only while the block has let go, so no fight
   assign pin_out = blk_oe_in ? blk_bus_in : data_in;
   assign lines_out = lines_in;
endmodule

//--- bpp_port_regs_checker.sv
// Port-level assertions for the printer port register block
`timescale 1ns/10ps
module bpp_port_regs_checker (
   input wire logic sys_clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic port_chip_select_n_in, // Select
   input wire logic io_read_strobe_n_in, // Read
   input wire logic io_write_strobe_n_in, // Write
   input wire logic [2:0] addr_in, // Address
   input wire logic [7:0] host_data_in, // Write data
   input wire logic [7:0] host_data_out, // Read data
   input wire logic [7:0] port_bus_out, // Bus value
   input wire logic port_bus_oe_out, // Bus drive
   input wire logic direction_pin_in, // Direction pin
   input wire logic extended_bus_mode_in, // Bus mode
   input wire logic strobe_out, // Line
   input wire logic autofeed_out, // Line
   input wire logic init_out, // Line
   input wire logic select_printer_out, // Line
   input wire logic port_irq_out, // Gated irq
   input wire logic [1:0] serial0_clock_source_out, // Clock code
   input wire logic [2:0] indirect_index_field_out, // Index
   input wire logic indirect_wr_out, // Pulse
   input wire logic clock_select_wr_out, // Pulse
   input wire logic clock_disable_wr_out // Pulse
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   logic wr_n_q, rd_n_q, irq_en_q, dir_q;
   wire wr_go = !port_chip_select_n_in && !io_write_strobe_n_in && io_read_strobe_n_in && wr_n_q;
   wire rd_go = !port_chip_select_n_in && !io_read_strobe_n_in && io_write_strobe_n_in && rd_n_q;
   wire ctl_go = wr_go && addr_in[1:0] == 2'h2;
   wire [3:0] lines = {select_printer_out, init_out, autofeed_out, strobe_out};
   // Strobes start deasserted so the first cycle after reset counts
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         irq_en_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         wr_n_q <= io_write_strobe_n_in;
         rd_n_q <= io_read_strobe_n_in;
         if (ctl_go) begin
            irq_en_q <= host_data_in[4];
            dir_q <= host_data_in[5];
         end
      end
   end
   property p_data_wr;
      wr_go && addr_in[1:0] == 2'h0 |=> port_bus_out == $past(host_data_in);
   endproperty
   a_data_wr: assert property (p_data_wr) else $error("data write lost");
   property p_ctrl_wr;
      ctl_go |=> lines == $past(host_data_in[3:0]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("line outputs wrong");
   property p_ctrl_rd;
      rd_go && addr_in[1:0] == 2'h2 |=> host_data_out == {3'h7, $past(irq_en_q), $past(lines)};
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
   property p_compat_dir;
      !extended_bus_mode_in |-> port_bus_oe_out == !direction_pin_in;
   endproperty
   a_compat_dir: assert property (p_compat_dir) else $error("compat direction");
   property p_ext_dir;
      extended_bus_mode_in |-> port_bus_oe_out == !(direction_pin_in && dir_q);
   endproperty
   a_ext_dir: assert property (p_ext_dir) else $error("extended direction");
   property p_irq_gate;
      !irq_en_q |-> !port_irq_out;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
   property p_idx_wr;
      wr_go && addr_in == 3'h3 |=>
         {serial0_clock_source_out, indirect_index_field_out} == $past(host_data_in[4:0]);
   endproperty
   a_idx_wr: assert property (p_idx_wr) else $error("index write lost");
   property p_clk_sel;
      wr_go && addr_in == 3'h7 && indirect_index_field_out == 3'h0 |=>
         clock_select_wr_out && indirect_wr_out ##1 !clock_select_wr_out;
   endproperty
   a_clk_sel: assert property (p_clk_sel) else $error("clock select pulse");
   property p_park;
      wr_go && addr_in == 3'h7 && indirect_index_field_out > 3'h5 |=>
         !indirect_wr_out && !clock_select_wr_out && !clock_disable_wr_out;
   endproperty
   a_park: assert property (p_park) else $error("parked index wrote");
   c_ctrl_rd: cover property (rd_go && addr_in[1:0] == 2'h2);
   c_clk_dis: cover property (clock_disable_wr_out);
   c_ext_rd: cover property (extended_bus_mode_in && !port_bus_oe_out);
endmodule

//--- bpp_port_regs_tb.sv
// Self-checking testbench for the printer port register block
`timescale 1ns/10ps
module bpp_port_regs_tb;
   logic clk, rst, cs_n, rd_n, wr_n, dpin, ebm, eim, src, s0i, s1i;
   logic [2:0] adr, pulses;
   logic [7:0] hdi, pdat, rdat, v;
   logic [4:0] pl;
   logic rp;
   wire [7:0] hdo, pbo, pbi, iwd;
   wire [4:0] st;
   wire [1:0] s0c;
   wire [2:0] idf;
   wire hoe, poe, stb, afd, ini, sli, pirq, m0, m1, mp, iwr, ird, csw, cdw;
   int n_errors, tests_run, cyc;
   bpp_port_regs u_dut (.sys_clk_in(clk), .rst_in(rst), .port_chip_select_n_in(cs_n),
      .io_read_strobe_n_in(rd_n), .io_write_strobe_n_in(wr_n), .addr_in(adr),
      .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_out(hoe), .port_bus_in(pbi),
      .port_bus_out(pbo), .port_bus_oe_out(poe), .direction_pin_in(dpin), .busy_in(st[4]),
      .ack_in(st[3]), .paper_end_in(st[2]), .selected_in(st[1]), .error_in(st[0]),
      .strobe_out(stb), .autofeed_out(afd), .init_out(ini), .select_printer_out(sli),
      .extended_bus_mode_in(ebm), .extended_interrupt_mode_in(eim), .port_irq_src_in(src),
      .serial0_irq_in(s0i), .serial1_irq_in(s1i), .port_irq_out(pirq),
      .mux_serial0_irq_out(m0), .mux_serial1_irq_out(m1), .mux_port_irq_out(mp),
      .serial0_clock_source_out(s0c), .indirect_index_field_out(idf),
      .indirect_wdata_out(iwd), .indirect_wr_out(iwr), .indirect_rd_out(ird),
      .indirect_rdata_in(rdat), .clock_select_wr_out(csw), .clock_disable_wr_out(cdw));
   bpp_printer_model u_prn (.blk_bus_in(pbo), .blk_oe_in(poe), .data_in(pdat),
      .lines_in(pl), .pin_out(pbi), .lines_out(st));
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      wr_n <= 1'b0;
      adr <= a;
      hdi <= d;
      @(posedge clk);
      #1 pulses = {iwr, csw, cdw};
      @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      adr <= a;
      @(posedge clk);
      #1 v = hdo;
      rp = ird;
      chk(nm, e, v);
      chk("read oe", 8'h01, {7'h0, hoe});
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask
   task automatic t_data();
      chk("reset lines", 8'h00, {4'h0, sli, ini, afd, stb});
      chk("reset data", 8'h00, pbo);
      rc(3'h2, 8'hE0, "reset ctrl");
      wr(3'h0, 8'hA5);
      chk("drive", 8'h01, {7'h0, poe});
      rc(3'h4, 8'hA5, "data rd");
      @(posedge clk);
      dpin <= 1'b1;
      rc(3'h0, 8'h3C, "pin rd");
      wr(3'h1, 8'h00);
      chk("data kept", 8'hA5, pbo);
      @(posedge clk);
      dpin <= 1'b0;
      $display("test data done");
   endtask
   task automatic t_ctrl();
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         pl <= i ? 5'h15 : 5'h0A;
         rc(3'h1, i ? 8'hAF : 8'h57, "status");
      end
      wr(3'h2, 8'hFF);
      chk("lines", 8'h0F, {4'h0, sli, ini, afd, stb});
      rc(3'h2, 8'hFF, "ctrl ff");
      wr(3'h2, 8'hC0);
      rc(3'h2, 8'hE0, "ctrl c0");
      wr(3'h2, 8'h35);
      chk("lines", 8'h05, {4'h0, sli, ini, afd, stb});
      rc(3'h6, 8'hF5, "ctrl 35");
      $display("test control done");
   endtask
   task automatic t_dir();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         ebm <= i[2];
         dpin <= i[1];
         wr(3'h2, {2'h0, i[0], 5'h0});
         chk("dir", {7'h0, i[2] ? !(i[1] && i[0]) : !i[1]}, {7'h0, poe});
      end
      @(posedge clk);
      ebm <= 1'b0;
      dpin <= 1'b0;
      $display("test direction done");
   endtask
   task automatic t_irq();
      @(posedge clk);
      src <= 1'b1;
      #1 chk("irq off", 8'h00, {7'h0, pirq});
      wr(3'h2, 8'h10);
      chk("irq on", 8'h01, {7'h0, pirq});
      @(posedge clk);
      src <= 1'b0;
      eim <= 1'b1;
      @(posedge clk);
      src <= 1'b1;
      @(posedge clk);
      src <= 1'b0;
      rc(3'h1, 8'hAB, "sticky int");
      rc(3'h1, 8'hAF, "int cleared");
      @(posedge clk);
      eim <= 1'b0;
      $display("test interrupt done");
   endtask
   task automatic t_index();
      for (int c = 0; c < 4; c++) begin
         wr(3'h3, {3'h0, 2'(c), 3'h7});
         chk("sp0 clk", 8'(c), {6'h0, s0c});
      end
      wr(3'h3, 8'h00);
      wr(3'h7, 8'h5A);
      chk("sel pulse", 8'h06, {5'h0, pulses});
      chk("wdata", 8'h5A, iwd);
      wr(3'h3, 8'h01);
      wr(3'h7, 8'h33);
      chk("dis pulse", 8'h05, {5'h0, pulses});
      rc(3'h3, 8'h01, "index rd");
      rc(3'h7, 8'h96, "indirect rd");
      chk("rd pulse", 8'h01, {7'h0, rp});
      @(posedge clk);
      pl <= 5'h12;
      wr(3'h3, 8'h87);
      chk("mux", 8'h06, {5'h0, m1, m0, mp});
      wr(3'h7, 8'h11);
      chk("parked", 8'h00, {5'h0, pulses});
      rc(3'h7, 8'hFF, "parked rd");
      chk("parked rd pulse", 8'h00, {7'h0, rp});
      $display("test index done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard, well above the roughly 140 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      {rst, cs_n, rd_n, wr_n} = 4'hF;
      {dpin, ebm, eim, src, s0i, s1i} = 6'h0;
      adr = 3'h0;
      hdi = 8'h00;
      pdat = 8'h3C;
      rdat = 8'h96;
      pl = 5'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_data();
      t_ctrl();
      t_dir();
      t_irq();
      t_index();
      report_and_stop();
   end
endmodule
bind bpp_port_regs bpp_port_regs_checker u_chk (.sys_clk_in, .rst_in, .port_chip_select_n_in,
   .io_read_strobe_n_in, .io_write_strobe_n_in, .addr_in, .host_data_in, .host_data_out,
   .port_bus_out, .port_bus_oe_out, .direction_pin_in, .extended_bus_mode_in, .strobe_out,
   .autofeed_out, .init_out, .select_printer_out, .port_irq_out, .serial0_clock_source_out,
   .indirect_index_field_out, .indirect_wr_out, .clock_select_wr_out, .clock_disable_wr_out);
